//--- tb/brake_horn_inhibit_control_properties.sv
/* port checks for the brake, horn and inhibit block.
 * assumes it is bound to the top module; one clock domain. */
`timescale 1ns/1ps
`include "bhi_consts.vh"

module brake_horn_inhibit_control_properties (
    input wire       ref_clk,
    input wire       resetn,
    input wire       psel,
    input wire       penable,
    input wire       pready,
    input wire       pslverr,
    input wire [6:0] speedCmd,
    input wire       brakeCoilFault,
    input wire [6:0] speedLimited,
    input wire       driveInhibit,
    input wire       brakeEngaged,
    input wire [7:0] coilLevel,
    input wire       brakeFault
);
    // ==========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // release then a run of peak drive
    sequence releaseSeq;
        $fell(brakeEngaged);
    endsequence
    sequence peakSeq;
        (coilLevel == `PEAK_LEVEL) [*4];
    endsequence
    AST_PREADY: assert property (pready)
        else $error("wait state inserted");
    AST_SLVERR: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    AST_COIL_OFF: assert property (brakeEngaged |-> coilLevel == 8'h00)
        else $error("coil driven while engaged");
    AST_PEAK: assert property (releaseSeq |-> peakSeq)
        else $error("no peak drive on release");
    AST_BLOCK: assert property (driveInhibit |-> speedLimited == 7'h00)
        else $error("drive while blocked");
    AST_CAP: assert property (speedLimited <= $past(speedCmd))
        else $error("speed above command");
    AST_FAULT: assert property (brakeFault |-> $past(brakeCoilFault, 2) ||
        $past(brakeCoilFault, 3) || $past(brakeCoilFault, 4))
        else $error("fault without cause");
    AST_ENGAGE: assert property ($rose(brakeEngaged) |->
        $past(speedLimited) == 7'h00)
        else $error("engaged while moving");
endmodule // brake_horn_inhibit_control_properties

bind brake_horn_inhibit_control brake_horn_inhibit_control_properties
    brake_horn_inhibit_control_properties_inst (.ref_clk(ref_clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .speedCmd(speedCmd),
    .brakeCoilFault(brakeCoilFault), .speedLimited(speedLimited),
    .driveInhibit(driveInhibit), .brakeEngaged(brakeEngaged),
    .coilLevel(coilLevel), .brakeFault(brakeFault));

//--- tb/brake_inhibit_partner.sv
/* far side: inhibit switch wiring and brake coil.
 * assumes the bench asks for a pin state and a coil break. */
`timescale 1ns/1ps

module brake_inhibit_partner (
    // clock
    input  wire       ref_clk,
    // wanted state: 0 low rail, 1 high rail, 2 open
    input  wire [1:0] pinState,
    input  wire       coilOpen,
    // pins
    output reg        inhPinLow,
    output reg        inhPinHigh,
    output reg        brakeCoilFault
);
    // ==========================================================
    // pin levels, changed just after the edge like a real switch
    initial begin
        inhPinLow = 1'b0;
        inhPinHigh = 1'b0;
        brakeCoilFault = 1'b0;
    end
    always @(posedge ref_clk) begin
        inhPinLow <= (pinState == 2'd0);
        inhPinHigh <= (pinState == 2'd1);
        brakeCoilFault <= coilOpen;
    end
endmodule // brake_inhibit_partner

//--- tb/test_brake_horn_inhibit_control.sv
/* bench: apb tasks, a small reference model, timed scenarios.
 * assumes the partner drives the inhibit and coil pins and the ms tick is short. */
`timescale 1ns/1ps
`include "bhi_consts.vh"

module test_brake_horn_inhibit_control;
    // ==========================================================
    localparam MS = 4; // short ms tick keeps the run brief
    reg         ref_clk, resetn, psel, penable, pwrite;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, q;
    reg  [1:0]  pinState;
    reg         coilOpen, reverseSwitch, hornButton, reverseDir, err;
    reg         throttleNeutral, faultPresent, ledPattern;
    reg  [6:0]  speedCmd;
    wire [31:0] prdata;
    wire        pready, pslverr, inhPinLow, inhPinHigh, brakeCoilFault;
    wire [6:0]  speedLimited;
    wire [7:0]  coilLevel;
    wire        driveInhibit, brakeEngaged, brakeFault, hornOut, irq;
    int         fails, checkCount, n, t, p, cmd, cap;
    int         rstVal [4] = '{8'h08, 0, 0, 8'h80}; // reset table

    brake_horn_inhibit_control #(.MS_CYCLES(MS))
        brake_horn_inhibit_control_inst (.ref_clk(ref_clk),
        .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .inhPinLow(inhPinLow), .inhPinHigh(inhPinHigh),
        .reverseSwitch(reverseSwitch), .brakeCoilFault(brakeCoilFault),
        .hornButton(hornButton), .speedCmd(speedCmd),
        .reverseDir(reverseDir), .throttleNeutral(throttleNeutral),
        .faultPresent(faultPresent), .ledPattern(ledPattern),
        .speedLimited(speedLimited), .driveInhibit(driveInhibit),
        .brakeEngaged(brakeEngaged), .coilLevel(coilLevel),
        .brakeFault(brakeFault), .hornOut(hornOut), .irq(irq));
    brake_inhibit_partner brake_inhibit_partner_inst (.ref_clk(ref_clk),
        .pinState(pinState), .coilOpen(coilOpen), .inhPinLow(inhPinLow),
        .inhPinHigh(inhPinHigh), .brakeCoilFault(brakeCoilFault));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // ==========================================================
    task check(input [31:0] seen, input [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask
    task printVerdict;
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one apb transfer; read data lands in q
    task apb(input logic w, input [11:0] a, input [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            fails++;
            printVerdict;
        end
    endtask
    function logic pick(input int sel);
        case (sel)
            0: pick = brakeEngaged;
            1: pick = hornOut;
            default: pick = (coilLevel == `PEAK_LEVEL);
        endcase
    endfunction
    // bounded wait, n counts the cycles spent
    task waitSig(input int sel, input logic v, input int lim);
        n = 0;
        @(negedge ref_clk);
        while (pick(sel) !== v && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= lim) begin
            fails++;
            printVerdict;
        end
    endtask
    task settle(input int c);
        repeat (c) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task near(input int exp, input int tol);
        check((n >= exp - tol) && (n <= exp + tol), 1);
    endtask
    // reference decode: types 0..2 active at state, 3..5 inverted
    function int inhAct(input int ty, input int ps);
        inhAct = (ty < 3) ? (ps == ty) : (ps != ty - 3);
    endfunction
    // ==========================================================
    initial begin
        {psel, penable, pwrite, coilOpen, reverseSwitch} = 5'h0;
        {hornButton, reverseDir, throttleNeutral} = 3'h0;
        {faultPresent, ledPattern, paddr, pwdata} = 46'h0;
        pinState = 2'd2;
        speedCmd = 7'h00;
        fails = 0;
        checkCount = 0;
        resetn = 1'b0;
        void'($urandom(51698));
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        for (t = 0; t < 4; t++) begin
            apb(0, 4 * t, 0);
            check(q, rstVal[t]);
            check(err, 0);
        end
        apb(0, 12'h0FC, 0);
        check(q, 0);
        check(err, 1);
        apb(1, `OFS_INH_SPEED, 120);
        apb(0, `OFS_INH_SPEED, 0);
        check(q, 100);
        apb(1, `OFS_BRAKE_DELAY, 1500);
        apb(0, `OFS_BRAKE_DELAY, 0);
        check(q, 1000);
        // inhibit types 0..5 against every pin state
        for (t = 0; t < 6; t++)
            for (p = 0; p < 3; p++) begin
                cmd = 1 + $urandom % 100;
                cap = (p == 1) ? 0 : 1 + $urandom % 100;
                apb(1, `OFS_INH_SPEED, cap);
                apb(1, `OFS_CTRL, t);
                @(posedge ref_clk);
                pinState <= p;
                speedCmd <= cmd;
                settle(8);
                check(speedLimited, inhAct(t, p) && cmd > cap ? cap : cmd);
                check(driveInhibit, inhAct(t, p) && cap == 0);
                apb(0, `OFS_STATUS, 0);
                check(q[3], inhAct(t, p));
            end
        // peak then hold, delay, speed back during delay
        apb(1, `OFS_CTRL, 8'h08);
        apb(1, `OFS_BRAKE_DELAY, 3);
        apb(1, `OFS_HOLD_LEVEL, 8'h5A);
        @(posedge ref_clk);
        speedCmd <= 0;
        waitSig(0, 1, 6000);
        @(posedge ref_clk);
        speedCmd <= 50;
        waitSig(2, 1, 10);
        waitSig(2, 0, 5000);
        near(1000 * MS, MS + 2);
        check(coilLevel, 8'h5A);
        @(posedge ref_clk);
        speedCmd <= 0;
        settle(MS);
        check(brakeEngaged, 0);
        @(posedge ref_clk);
        speedCmd <= 40;
        settle(3);
        check(coilLevel, 8'h5A);
        @(posedge ref_clk);
        speedCmd <= 0;
        waitSig(0, 1, 100);
        near(3 * MS, MS + 3);
        check(coilLevel, 0);
        // coil fault, interrupt raise, mask and clear
        apb(1, `OFS_IRQ_STAT, 32'hF);
        apb(1, `OFS_IRQ_MASK, 32'h4);
        @(posedge ref_clk);
        coilOpen <= 1'b1;
        settle(8);
        check(brakeFault, 1);
        check(irq, 1);
        apb(1, `OFS_IRQ_STAT, 32'h4);
        settle(1);
        check(irq, 0);
        apb(1, `OFS_CTRL, 0);
        settle(2);
        check(brakeFault, 0);
        // horn, reverse tones and fault priority
        @(posedge ref_clk);
        coilOpen <= 1'b0;
        hornButton <= 1'b1;
        settle(6);
        check(hornOut, 1);
        @(posedge ref_clk);
        hornButton <= 1'b0;
        apb(1, `OFS_CTRL, 8'hC0);
        @(posedge ref_clk);
        reverseSwitch <= 1'b1;
        settle(6);
        check(hornOut, 1);
        apb(1, `OFS_CTRL, 8'hE0);
        @(posedge ref_clk);
        faultPresent <= 1'b1;
        settle(3);
        check(hornOut, 0);
        @(posedge ref_clk);
        ledPattern <= 1'b1;
        settle(3);
        check(hornOut, 1);
        @(posedge ref_clk);
        {faultPresent, ledPattern, reverseSwitch, reverseDir} <= 4'h1;
        speedCmd <= 30;
        settle(6);
        check(hornOut, 1);
        apb(1, `OFS_CTRL, 8'h40);
        waitSig(1, 0, 3000);
        waitSig(1, 1, 3000);
        near(500 * MS, 3);
        waitSig(1, 0, 3000);
        near(500 * MS, 3);
        // brake light: fault beep left off in light mode
        @(posedge ref_clk);
        reverseDir <= 1'b0;
        apb(1, `OFS_CTRL, 8'h10);
        @(posedge ref_clk);
        throttleNeutral <= 1'b1;
        speedCmd <= 0;
        settle(3);
        check(hornOut, 1);
        waitSig(0, 1, 100);
        waitSig(1, 0, 9000);
        near(2000 * MS, MS + 3);
        printVerdict;
    end
endmodule // test_brake_horn_inhibit_control

//--- verilog/bhi_consts.vh
/*
 * constants for the brake, horn and speed-inhibit control block:
 * register offsets, field positions, reset values and timing counts.
 * assumes it is included by bare name from the control block, the bench and the property checker.
 */
`ifndef BHI_CONSTS_VH
`define BHI_CONSTS_VH

// ==========================================================
// clock and time base
// ==========================================================
`define CLK_HZ              25000000
`define MS_PER_S            1000
// cycles of ref_clk per millisecond tick
`define MS_CYCLES           (`CLK_HZ / `MS_PER_S)

// ==========================================================
// timing figures in milliseconds, the beep rate in Hz and the speed cap in percent
// ==========================================================
`define PEAK_TIME_MS        1000
`define LIGHT_AFTER_MS      2000
`define BEEP_HZ             1
// half period of the pulsed reverse beep
`define BEEP_HALF_MS        (`MS_PER_S / (2 * `BEEP_HZ))
`define DELAY_MAX_MS        1000
`define SPEED_MAX_PCT       100

// ==========================================================
// register byte offsets
// ==========================================================
`define OFS_CTRL            12'h000
`define OFS_INH_SPEED       12'h004
`define OFS_BRAKE_DELAY     12'h008
`define OFS_HOLD_LEVEL      12'h00C
`define OFS_STATUS          12'h010
`define OFS_IRQ_STAT        12'h014
`define OFS_IRQ_MASK        12'h018

// ==========================================================
// control register fields
// ==========================================================
`define CTRL_TYPE_LSB       0
`define CTRL_TYPE_MSB       2
`define CTRL_FAULT_CHECK    3
`define CTRL_BRAKE_LIGHT    4
`define CTRL_FAULT_BEEP     5
`define CTRL_REV_BEEP       6
`define CTRL_BEEP_CONST     7
`define CTRL_WIDTH          8

// ==========================================================
// reset values and the peak coil level
// ==========================================================
`define RST_CTRL            8'h08
`define RST_INH_SPEED       7'h00
`define RST_BRAKE_DELAY     10'h000
`define RST_HOLD_LEVEL      8'h80
`define PEAK_LEVEL          8'hFF

// ==========================================================
// interrupt event bits
// ==========================================================
`define EV_ENGAGED          0
`define EV_RELEASED         1
`define EV_BRAKE_FAULT      2
`define EV_INHIBIT          3
`define EV_WIDTH            4

`endif

//--- verilog/brake_horn_inhibit_control.v
/*
 * speed inhibit, brake sequencing and shared horn output control,
 * with an apb register file and one level interrupt.
 * assumes speed command, direction, neutral, fault and led pattern
 * come from logic on ref_clk; pin levels arrive asynchronously.
 *
 */
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "bhi_consts.vh"

module brake_horn_inhibit_control #(
    parameter MS_CYCLES = `MS_CYCLES
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        resetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // pins, asynchronous
    input  wire        inhPinLow,
    input  wire        inhPinHigh,
    input  wire        reverseSwitch,
    input  wire        brakeCoilFault,
    input  wire        hornButton,
    // from throttle and fault logic, same clock
    input  wire [6:0]  speedCmd,
    input  wire        reverseDir,
    input  wire        throttleNeutral,
    input  wire        faultPresent,
    input  wire        ledPattern,
    // outputs
    output reg  [6:0]  speedLimited,
    output reg         driveInhibit,
    output reg         brakeEngaged,
    output reg  [7:0]  coilLevel,
    output reg         brakeFault,
    output reg         hornOut,
    output wire        irq
);

// ==========================================================
// state codes
// ==========================================================
localparam [1:0] ST_ENGAGED = 2'd0;  // coil off, brake holds
localparam [1:0] ST_PEAK    = 2'd1;  // released, peak drive
localparam [1:0] ST_HOLD    = 2'd2;  // released, hold drive
localparam [1:0] ST_DELAY   = 2'd3;  // zero speed, counting up to the delay

localparam [11:0] PEAK_MS  = `PEAK_TIME_MS;
localparam [11:0] LIGHT_MS = `LIGHT_AFTER_MS;
localparam [11:0] HALF_MS  = `BEEP_HALF_MS;
localparam [6:0]  MAX_PCT  = `SPEED_MAX_PCT;
localparam [9:0]  MAX_DLY  = `DELAY_MAX_MS;

// ==========================================================
// pin synchronisers and time base
// ==========================================================
wire [4:0] pinSync;  // synchronised pin levels
wire       msTick;   // one pulse per millisecond

sync_bits #(
    .WIDTH   (5)
) u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .asyncIn ({hornButton, brakeCoilFault, reverseSwitch,
               inhPinHigh, inhPinLow}),
    .syncOut (pinSync)
);

tick_divider #(
    .DIV     (MS_CYCLES)
) u_tick (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tick    (msTick)
);

wire atNeg   = pinSync[0];  // pin pulled to negative rail
wire atPos   = pinSync[1];  // pin pulled to positive rail
wire revSw   = pinSync[2];  // reverse switch closed
wire coilBad = pinSync[3];  // coil fault sense
wire hornBtn = pinSync[4];  // horn push button

// ==========================================================
// register file
// ==========================================================
reg  [7:0]  ctrl_q;       // mode and enable bits
reg  [6:0]  inhSpeed_q;   // inhibit speed cap, percent
reg  [9:0]  brakeDly_q;   // engage delay, ms
reg  [7:0]  holdLevel_q;  // coil hold level
reg  [3:0]  irqStat_q;    // sticky events
reg  [3:0]  irqMask_q;    // event enables
reg  [3:0]  irqStat_d;
reg  [3:0]  events;       // one-cycle event pulses

wire [2:0] inhType    = ctrl_q[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB];
wire       faultCheck = ctrl_q[`CTRL_FAULT_CHECK];
wire       lightMode  = ctrl_q[`CTRL_BRAKE_LIGHT];
wire       faultBeep  = ctrl_q[`CTRL_FAULT_BEEP];
wire       revBeep    = ctrl_q[`CTRL_REV_BEEP];
wire       beepConst  = ctrl_q[`CTRL_BEEP_CONST];

// apb answers in the access cycle, never waits
assign pready = 1'b1;
wire   access  = psel & penable;
wire   wrEn    = access & pwrite;
wire   mapped  = (paddr == `OFS_CTRL) | (paddr == `OFS_INH_SPEED) |
                 (paddr == `OFS_BRAKE_DELAY) |
                 (paddr == `OFS_HOLD_LEVEL) | (paddr == `OFS_STATUS) |
                 (paddr == `OFS_IRQ_STAT) | (paddr == `OFS_IRQ_MASK);
assign pslverr = access & ~mapped;
wire   statClr = wrEn & (paddr == `OFS_IRQ_STAT);

// write side; out-of-range speed cap and brake delay values are clamped on write
always @(posedge ref_clk) begin
    if (!resetn) begin
        ctrl_q      <= `RST_CTRL;
        inhSpeed_q  <= `RST_INH_SPEED;
        brakeDly_q  <= `RST_BRAKE_DELAY;
        holdLevel_q <= `RST_HOLD_LEVEL;
        irqMask_q   <= 4'h0;
    end else if (wrEn) begin
        case (paddr)
            `OFS_CTRL:        ctrl_q      <= pwdata[7:0];
            `OFS_INH_SPEED:   inhSpeed_q  <= (pwdata > {25'h0, MAX_PCT}) ?
                                             MAX_PCT : pwdata[6:0];
            `OFS_BRAKE_DELAY: brakeDly_q  <= (pwdata > {22'h0, MAX_DLY}) ?
                                             MAX_DLY : pwdata[9:0];
            `OFS_HOLD_LEVEL:  holdLevel_q <= pwdata[7:0];
            `OFS_IRQ_MASK:    irqMask_q   <= pwdata[3:0];
            default:          ;
        endcase
    end
end

// sticky status: a new event wins over a same-cycle clear
always @* begin
    irqStat_d = irqStat_q & ~(statClr ? pwdata[3:0] : 4'h0);
    irqStat_d = irqStat_d | events;
end

always @(posedge ref_clk) begin
    if (!resetn) begin
        irqStat_q <= 4'h0;
    end else begin
        irqStat_q <= irqStat_d;
    end
end

assign irq = |(irqStat_q & irqMask_q);

// ==========================================================
// inhibit decode and speed cap
// ==========================================================
reg        inhActive;   // decoded inhibit condition
reg        inhPrev_q;   // for change event
wire       openCirc = ~atNeg & ~atPos;

always @* begin
    case (inhType)
        3'd0:    inhActive = atNeg;
        3'd1:    inhActive = atPos;
        3'd2:    inhActive = openCirc;
        3'd3:    inhActive = ~atNeg;
        3'd4:    inhActive = ~atPos;
        3'd5:    inhActive = ~openCirc;
        default: inhActive = 1'b0;  // undefined types never inhibit
    endcase
end

always @(posedge ref_clk) begin
    if (!resetn) begin
        speedLimited <= 7'h00;
        driveInhibit <= 1'b0;
        inhPrev_q    <= 1'b0;
    end else begin
        inhPrev_q    <= inhActive;
        driveInhibit <= inhActive & (inhSpeed_q == 7'h00);
        if (inhActive && speedCmd > inhSpeed_q) begin
            speedLimited <= inhSpeed_q;
        end else begin
            speedLimited <= speedCmd;
        end
    end
end

// ==========================================================
// brake sequencer
// ==========================================================
reg  [1:0]  state_q;     // brake state
reg  [1:0]  state_d;
reg  [11:0] msCnt_q;     // ms spent in the timed state
wire        wantDrive = (speedLimited != 7'h00);

always @* begin
    state_d = state_q;
    case (state_q)
        ST_ENGAGED: if (wantDrive) begin
            state_d = ST_PEAK;
        end
        ST_PEAK: if (!wantDrive) begin
            state_d = ST_DELAY;
        end else if (msTick && msCnt_q >= PEAK_MS - 12'd1) begin
            state_d = ST_HOLD;
        end
        ST_HOLD: if (!wantDrive) begin
            state_d = ST_DELAY;
        end
        ST_DELAY: if (wantDrive) begin
            state_d = ST_HOLD;
        end else if (msCnt_q >= {2'b00, brakeDly_q}) begin
            state_d = ST_ENGAGED;
        end
        default: state_d = ST_ENGAGED;
    endcase
end

// state, timer and coil drive; timer restarts on every state change
always @(posedge ref_clk) begin
    if (!resetn) begin
        state_q      <= ST_ENGAGED;
        msCnt_q      <= 12'h000;
        brakeEngaged <= 1'b1;
        coilLevel    <= 8'h00;
    end else begin
        state_q <= state_d;
        if (state_d != state_q) begin
            msCnt_q <= 12'h000;
        end else if (msTick && msCnt_q != 12'hFFF) begin
            msCnt_q <= msCnt_q + 12'h001;
        end
        brakeEngaged <= (state_d == ST_ENGAGED);
        case (state_d)
            ST_PEAK:  coilLevel <= `PEAK_LEVEL;
            ST_HOLD:  coilLevel <= holdLevel_q;
            ST_DELAY: coilLevel <= holdLevel_q;
            default:  coilLevel <= 8'h00;
        endcase
    end
end

always @(posedge ref_clk) begin
    if (!resetn) begin
        brakeFault <= 1'b0;
    end else begin
        brakeFault <= faultCheck & coilBad;
    end
end

// event pulses for the interrupt status
always @* begin
    events = 4'h0;
    events[`EV_ENGAGED]     = (state_d == ST_ENGAGED) &
                              (state_q != ST_ENGAGED);
    events[`EV_RELEASED]    = (state_q == ST_ENGAGED) &
                              (state_d != ST_ENGAGED);
    events[`EV_BRAKE_FAULT] = faultCheck & coilBad & ~brakeFault;
    events[`EV_INHIBIT]     = inhActive ^ inhPrev_q;
end

// ==========================================================
// brake light timing
// ==========================================================
reg         lightOn_q;   // light relay request
reg  [11:0] lightCnt_q;  // ms since brake engaged

always @(posedge ref_clk) begin
    if (!resetn) begin
        lightOn_q  <= 1'b0;
        lightCnt_q <= 12'h000;
    end else begin
        if (state_q != ST_ENGAGED) begin
            lightCnt_q <= 12'h000;
        end else if (msTick && lightCnt_q != LIGHT_MS) begin
            lightCnt_q <= lightCnt_q + 12'h001;
        end
        // set wins so a fresh neutral is never missed
        if (throttleNeutral && state_q != ST_ENGAGED) begin
            lightOn_q <= 1'b1;
        end else if (state_q == ST_ENGAGED && lightCnt_q == LIGHT_MS) begin
            lightOn_q <= 1'b0;
        end
    end
end

// ==========================================================
// reverse beep pulse
// ==========================================================
reg  [11:0] beepCnt_q;    // ms in current half
reg         beepPhase_q;  // high in the sounding half
wire        revActive = revBeep & ((reverseDir & ~brakeEngaged) | revSw);

always @(posedge ref_clk) begin
    if (!resetn) begin
        beepCnt_q   <= 12'h000;
        beepPhase_q <= 1'b1;
    end else if (!revActive) begin
        // restart so every reverse begins with a tone
        beepCnt_q   <= 12'h000;
        beepPhase_q <= 1'b1;
    end else if (msTick) begin
        if (beepCnt_q == HALF_MS - 12'd1) begin
            beepCnt_q   <= 12'h000;
            beepPhase_q <= ~beepPhase_q;
        end else begin
            beepCnt_q <= beepCnt_q + 12'h001;
        end
    end
end

// ==========================================================
// shared horn output
// ==========================================================
// light mode selects relay
always @(posedge ref_clk) begin
    if (!resetn) begin
        hornOut <= 1'b0;
    end else if (lightMode) begin
        hornOut <= lightOn_q;
    end else if (faultBeep && faultPresent) begin
        hornOut <= ledPattern;
    end else if (revActive) begin
        hornOut <= beepConst | beepPhase_q;
    end else begin
        hornOut <= hornBtn;
    end
end

// ==========================================================
// read side
// ==========================================================
// read data registered in setup so it is valid in access
always @(posedge ref_clk) begin
    if (!resetn) begin
        prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
        case (paddr)
            `OFS_CTRL:        prdata <= {24'h00_0000, ctrl_q};
            `OFS_INH_SPEED:   prdata <= {25'h000_0000, inhSpeed_q};
            `OFS_BRAKE_DELAY: prdata <= {22'h00_0000, brakeDly_q};
            `OFS_HOLD_LEVEL:  prdata <= {24'h00_0000, holdLevel_q};
            `OFS_STATUS:      prdata <= {24'h00_0000, lightOn_q,
                                         hornOut, brakeFault,
                                         driveInhibit, inhActive,
                                         brakeEngaged, state_q};
            `OFS_IRQ_STAT:    prdata <= {28'h000_0000, irqStat_q};
            `OFS_IRQ_MASK:    prdata <= {28'h000_0000, irqMask_q};
            default:          prdata <= 32'h0000_0000;
        endcase
    end
end

endmodule // brake_horn_inhibit_control

//--- verilog/sync_bits.v
/*
 * two-flop synchroniser for a group of asynchronous pin levels.
 * assumes the inputs are slow levels; only the second stage is used.
 */
`timescale 1ns/1ps

module sync_bits #(
    parameter WIDTH = 4
) (
    // clock and reset
    input  wire             ref_clk,
    input  wire             resetn,
    // levels
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

// ==========================================================
// one flop pair per bit
// ==========================================================
genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
        reg stage1_q;  // read only by stage2_q
        reg stage2_q;  // safe copy
        // metastability settles in the first stage
        always @(posedge ref_clk) begin
            if (!resetn) begin
                stage1_q <= 1'b0;
                stage2_q <= 1'b0;
            end else begin
                stage1_q <= asyncIn[i];
                stage2_q <= stage1_q;
            end
        end
        assign syncOut[i] = stage2_q;
    end
endgenerate

endmodule // sync_bits

//--- verilog/tick_divider.v
/*
 * divider that turns ref_clk into a one-cycle enable pulse.
 * assumes DIV is at least 2.
 */
`timescale 1ns/1ps

module tick_divider #(
    parameter DIV = 25000
) (
    // clock and reset
    input  wire ref_clk,
    input  wire resetn,
    // enable pulse
    output reg  tick
);

// ==========================================================
// free-running counter
// ==========================================================
reg  [31:0] count_q;  // cycles since last tick

// wrap at DIV-1 and pulse once per wrap
always @(posedge ref_clk) begin
    if (!resetn) begin
        count_q <= 32'h0000_0000;
        tick    <= 1'b0;
    end else if (count_q == DIV - 1) begin
        count_q <= 32'h0000_0000;
        tick    <= 1'b1;
    end else begin
        count_q <= count_q + 32'h0000_0001;
        tick    <= 1'b0;
    end
end

endmodule // tick_divider
